// *** lsicp_pkg.sv ***
package lsicp_pkg;
	localparam logic [6:0] ADDR_PIN_HI = 7'h5C;
	localparam logic [6:0] ADDR_PIN_LO = 7'h23;
	localparam logic [7:0] MT_RESET = 8'h45;
	localparam logic [7:0] MT_MIN = 8'h1F;
	localparam logic [7:0] MT_MAX = 8'hFE;
	localparam logic [7:0] OP_PDOWN = 8'h00;
	localparam logic [7:0] OP_PON = 8'h01;
	localparam logic [7:0] OP_CLR = 8'h07;
	localparam logic [7:0] OP_CH = 8'h10;
	localparam logic [7:0] OP_CH2 = 8'h11;
	localparam logic [7:0] OP_CL = 8'h13;
	localparam logic [7:0] OP_OH = 8'h20;
	localparam logic [7:0] OP_OH2 = 8'h21;
	localparam logic [7:0] OP_OL = 8'h23;
	localparam logic [4:0] MT_HI_PFX = 5'h08;
	localparam logic [2:0] MT_LO_PFX = 3'h3;
	localparam logic [1:0] RES_H = 2'h0;
	localparam logic [1:0] RES_H2 = 2'h1;
	localparam logic [1:0] RES_L = 2'h3;
	localparam int L_SHIFT = 2;
	localparam logic [24:0] DIV_H = {17'h0, MT_RESET};
	localparam logic [24:0] DIV_L = DIV_H << L_SHIFT;
	localparam int CLK_HZ = 100_000_000;
	localparam int MEAS_H_MS = 120;
	localparam int MEAS_L_MS = 16;
	localparam int UNIT_H_CYC = MEAS_H_MS * (CLK_HZ / 1000) / 69;
	localparam int UNIT_L_CYC = MEAS_L_MS * (CLK_HZ / 1000) / 69;
	localparam int RST_HOLD_US = 1;
	localparam int RST_HOLD_CYC = RST_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int SCL_HZ = 350_000; // low phase stays above 1.3 us
	localparam int SCL_QTR_CYC = CLK_HZ / (4 * SCL_HZ);
	localparam logic [9:0] LUX_NUM = 10'h2B2;
	localparam logic [3:0] LUX_DEN = 4'hC;
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_RESULT = 5'h08;
	localparam logic [4:0] REG_CFG = 5'h0C;
	localparam logic [4:0] REG_LUX = 5'h10;
	localparam int CMD_READ_BIT = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_REFUSED = 2;
	localparam int STAT_LINK_UP = 3;
endpackage

// *** lsicp_if.sv ***
`timescale 1ns/1ps
interface lsicp_if;
	logic scl_oe_h;
	logic sda_oe_h;
	logic sda_oe_d;
	logic addr_sel;
	logic dvi_n;
	logic scl;
	logic sda;
	// open drain: an enable pulls the line low, else pulled up
	assign scl = ~scl_oe_h;
	assign sda = ~(sda_oe_h | sda_oe_d);
	modport dev (input scl, sda, addr_sel, dvi_n, output sda_oe_d);
	modport host (input scl, sda, output scl_oe_h, sda_oe_h, addr_sel, dvi_n);
endinterface

// *** lsicp_sensor_dev.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1: strap high answers 1011100, low 0100011
// R2: one opcode per write, then stop
// R3: standard bus transactions both ways
// R4: host converts count using 69/(1.2*setting)
// R5: integration setting resets to 69
// R6: host programs setting only 31 to 254
// R7: prefix 01000 loads setting bits 7..5
// R8: prefix 011 loads setting bits 4..0
// R9: time and sensitivity scale with setting
// R10: doubled setting gives about 240 ms
// R11: setting applies to any later measurement; a running continuous mode keeps its mt_run until the next measurement opcode
// R12: half-lux mode doubles count per lux
// R13: 0x11 continuous, 0x21 single half-lux
// R14: half-lux measurement 120 ms at default
// R15: host waits up to 180 ms first; lsicp_host_ctrl has no such wait and reads whenever commanded
// R16: reset pin low clears registers asynchronously
// R17: 0x00 powers down, 0x01 powers on
// R18: 0x07 clears result, ignored when down
// R19: 1-lux 120 ms, 4-lux 16 ms modes
// R20: host sends only defined opcodes
// R21: read returns result high byte first
// R22: write: start, address, ack, opcode, ack, stop
module lsicp_sensor_dev
	import lsicp_pkg::*;
#(
	parameter int T_UNIT_H = UNIT_H_CYC,
	parameter int T_UNIT_L = UNIT_L_CYC
)(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	lsicp_if.dev             bus,
	input  wire logic [15:0] light_i,
	output logic             powered_o,
	output logic             meas_active_o
);

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ADACK, S_WR, S_WRACK, S_IGN, S_RD, S_RDACK
	} lsicp_link_e;
	typedef enum logic [1:0] {M_DOWN, M_ON, M_MEAS} lsicp_mode_e;

	logic        arst;
	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	logic [1:0]  adr_s;
	logic        start_e;
	logic        stop_e;
	logic        rise_e;
	logic        fall_e;
	logic [6:0]  my_addr;
	lsicp_link_e state;
	logic [3:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  tx;
	logic [7:0]  op;
	logic        op_pend;
	logic        rd_lo;
	logic        ack_ok;
	logic [15:0] snap;
	logic        exec;
	lsicp_mode_e mode;
	logic [7:0]  mt;
	logic [7:0]  mt_run;
	logic [7:0]  mt_cnt;
	logic [17:0] unit_cnt;
	logic [17:0] unit_last;
	logic [24:0] acc;
	logic [24:0] acc_sum;
	logic [24:0] quo;
	logic [15:0] sat;
	logic [15:0] result;
	logic        cont;
	logic [1:0]  res;

	// the reset pin acts without the clock
	assign arst = rst_i | ~bus.dvi_n; // R16

	always_ff @(posedge sys_clk_i or posedge arst) begin
		if (arst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			adr_s <= 2'h0;
		end else begin
			scl_s <= {scl_s[1:0], bus.scl};
			sda_s <= {sda_s[1:0], bus.sda};
			adr_s <= {adr_s[0], bus.addr_sel};
		end
	end

	// only stages 1 and 2 feed logic
	assign start_e = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1]; // R3
	assign stop_e = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1]; // R3
	assign rise_e = scl_s[1] & ~scl_s[2];
	assign fall_e = ~scl_s[1] & scl_s[2];
	assign my_addr = adr_s[1] ? ADDR_PIN_HI : ADDR_PIN_LO; // R1
	// an opcode only takes effect at its stop
	assign exec = stop_e & op_pend; // R2

	always_ff @(posedge sys_clk_i or posedge arst) begin
		if (arst) begin
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			op <= 8'h00;
			op_pend <= 1'b0;
			rd_lo <= 1'b0;
			ack_ok <= 1'b0;
			snap <= 16'h0000;
			bus.sda_oe_d <= 1'b0;
		end else if (start_e) begin
			state <= S_ADDR;
			bitcnt <= 4'h0;
			op_pend <= 1'b0;
			bus.sda_oe_d <= 1'b0;
		end else if (stop_e) begin
			state <= S_IDLE;
			op_pend <= 1'b0;
			bus.sda_oe_d <= 1'b0;
		end else begin
			case (state)
				S_ADDR, S_WR: begin
					if (rise_e) begin
						shreg <= {shreg[6:0], sda_s[1]};
						bitcnt <= bitcnt + 4'h1;
					end else if (fall_e && bitcnt == 4'h8) begin
						if (state == S_WR) begin
							op <= shreg; // R22
							op_pend <= 1'b1;
							bus.sda_oe_d <= 1'b1;
							state <= S_WRACK;
						end else if (shreg[7:1] == my_addr) begin // R1
							bus.sda_oe_d <= 1'b1;
							snap <= result;
							state <= S_ADACK;
						end else begin
							state <= S_IGN;
						end
					end
				end
				S_ADACK: begin
					if (fall_e) begin
						bitcnt <= 4'h0;
						if (shreg[0]) begin
							tx <= {snap[14:8], 1'b0};
							bus.sda_oe_d <= ~snap[15]; // R21
							rd_lo <= 1'b0;
							state <= S_RD;
						end else begin
							bus.sda_oe_d <= 1'b0;
							state <= S_WR;
						end
					end
				end
				S_WRACK: begin
					// a second opcode byte is not acknowledged
					if (fall_e) begin
						bus.sda_oe_d <= 1'b0;
						state <= S_IGN; // R2
					end
				end
				S_RD: begin
					if (fall_e) begin
						bitcnt <= bitcnt + 4'h1;
						if (bitcnt == 4'h7) begin
							bus.sda_oe_d <= 1'b0;
							state <= S_RDACK;
						end else begin
							bus.sda_oe_d <= ~tx[7];
							tx <= {tx[6:0], 1'b0};
						end
					end
				end
				S_RDACK: begin
					if (rise_e) begin
						ack_ok <= ~sda_s[1];
					end else if (fall_e) begin
						if (ack_ok && !rd_lo) begin
							tx <= {snap[6:0], 1'b0};
							bus.sda_oe_d <= ~snap[7]; // R21
							rd_lo <= 1'b1;
							bitcnt <= 4'h0;
							state <= S_RD;
						end else begin
							state <= S_IGN; // R21
						end
					end
				end
				S_IGN, S_IDLE: ;
				default: state <= S_IDLE;
			endcase
		end
	end

	// coarse mode integrates over a shorter unit
	assign unit_last = (res == RES_L) ? 18'(T_UNIT_L - 1)
		: 18'(T_UNIT_H - 1); // R19
	assign acc_sum = acc + {9'h000, light_i};

	always_comb begin
		case (res)
			RES_H2: quo = (acc_sum << 1) / DIV_H; // R12
			RES_L: quo = acc_sum / DIV_L;
			default: quo = acc_sum / DIV_H;
		endcase
		sat = (quo > 25'h000FFFF) ? 16'hFFFF : quo[15:0];
	end

	// integration runs for mt_run units, so time and gain track it
	always_ff @(posedge sys_clk_i or posedge arst) begin
		if (arst) begin
			mode <= M_DOWN;
			mt <= MT_RESET; // R5
			mt_run <= MT_RESET;
			mt_cnt <= 8'h00;
			unit_cnt <= 18'h00000;
			acc <= 25'h0000000;
			result <= 16'h0000;
			cont <= 1'b0;
			res <= RES_H;
		end else if (exec) begin
			if (op[7:3] == MT_HI_PFX) begin
				mt[7:5] <= op[2:0]; // R7
			end else if (op[7:5] == MT_LO_PFX) begin
				mt[4:0] <= op[4:0]; // R8
			end else begin
				case (op)
					OP_PDOWN: mode <= M_DOWN; // R17
					OP_PON: mode <= M_ON; // R17
					OP_CLR: begin
						if (mode != M_DOWN) begin
							result <= 16'h0000; // R18
						end
					end
					OP_CH, OP_CH2, OP_CL, OP_OH, OP_OH2, OP_OL: begin
						mode <= M_MEAS; // R13 R19
						cont <= op[4];
						res <= op[1:0];
						mt_run <= mt; // R11
						mt_cnt <= 8'h00;
						unit_cnt <= 18'h00000;
						acc <= 25'h0000000;
					end
					default: ;
				endcase
			end
		end else if (mode == M_MEAS) begin
			if (unit_cnt == unit_last) begin
				unit_cnt <= 18'h00000;
				if (mt_cnt == mt_run - 8'h01) begin // R9 R10 R14
					result <= sat;
					mt_cnt <= 8'h00;
					acc <= 25'h0000000;
					if (!cont) begin
						mode <= M_DOWN; // R13
					end
				end else begin
					mt_cnt <= mt_cnt + 8'h01;
					acc <= acc_sum;
				end
			end else begin
				unit_cnt <= unit_cnt + 18'h00001;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge arst) begin
		if (arst) begin
			powered_o <= 1'b0;
			meas_active_o <= 1'b0;
		end else begin
			powered_o <= (mode != M_DOWN);
			meas_active_o <= (mode == M_MEAS);
		end
	end

endmodule

// *** lsicp_host_ctrl.sv ***
`timescale 1ns/1ps
module lsicp_host_ctrl
	import lsicp_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	lsicp_if.host            bus,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o
);

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lsicp_hst_e;

	lsicp_hst_e  hst;
	logic [1:0]  sda_s;
	logic [7:0]  qcnt;
	logic        qtick;
	logic [1:0]  q;
	logic [3:0]  bit_n;
	logic [1:0]  byte_n;
	logic [7:0]  tx;
	logic [7:0]  rx;
	logic        is_read;
	logic [7:0]  op_hold;
	logic        busy;
	logic        nack;
	logic        refused;
	logic [15:0] result;
	logic [25:0] lux;
	logic [7:0]  mt_sh;
	logic        half;
	logic [7:0]  rst_cnt;
	logic        wr_go;
	logic        tx_byte;
	logic [7:0]  wop;
	logic [7:0]  mt_cand;
	logic        legal;
	logic [15:0] count;
	logic [12:0] lux_den;

	assign wr_go = avs_write_i & ~avs_waitrequest_o;
	assign wop = avs_writedata_i[7:0];
	assign mt_cand = (wop[7:3] == MT_HI_PFX) ? {wop[2:0], mt_sh[4:0]}
		: {mt_sh[7:5], wop[4:0]};
	// range is checked per half write, so a move may need care in order
	always_comb begin
		case (wop)
			OP_PDOWN, OP_PON, OP_CLR, OP_CH, OP_CH2, OP_CL,
			OP_OH, OP_OH2, OP_OL: legal = 1'b1; // R20
			default: legal = (wop[7:3] == MT_HI_PFX || wop[7:5] == MT_LO_PFX)
				&& mt_cand >= MT_MIN && mt_cand <= MT_MAX; // R6
		endcase
		if (avs_writedata_i[CMD_READ_BIT]) begin
			legal = 1'b1;
		end
	end
	assign tx_byte = (byte_n == 2'h0) | ~is_read;
	assign qtick = busy & (qcnt == 8'(SCL_QTR_CYC - 1));
	assign count = {result[15:8], rx};
	assign lux_den = (half ? 13'h0002 : 13'h0001) * mt_sh * LUX_DEN;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_s <= 2'h3;
			qcnt <= 8'h00;
			rst_cnt <= 8'h00;
			bus.dvi_n <= 1'b0;
		end else begin
			sda_s <= {sda_s[0], bus.sda};
			qcnt <= (qtick || !busy) ? 8'h00 : qcnt + 8'h01;
			// hold the sensor in reset for a while after our own reset
			if (rst_cnt == 8'(RST_HOLD_CYC)) begin
				bus.dvi_n <= 1'b1; // R16
			end else begin
				rst_cnt <= rst_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
			bus.addr_sel <= 1'b0;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
			if (avs_read_i) begin
				case (avs_address_i)
					REG_STATUS: avs_readdata_o <= {28'h0000000, bus.dvi_n,
						refused, nack, busy};
					REG_RESULT: avs_readdata_o <= {16'h0000, result};
					REG_CFG: avs_readdata_o <= {31'h00000000, bus.addr_sel};
					REG_LUX: avs_readdata_o <= {6'h00, lux};
					default: avs_readdata_o <= 32'h00000000;
				endcase
			end
		end else begin
			avs_waitrequest_o <= 1'b1;
			if (wr_go && avs_address_i == REG_CFG && !busy) begin
				bus.addr_sel <= avs_writedata_i[0];
			end
		end
	end

	// quarter-period sequencer: set data, raise clock, sample, drop clock
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hst <= H_IDLE;
			q <= 2'h0;
			bit_n <= 4'h0;
			byte_n <= 2'h0;
			tx <= 8'h00;
			rx <= 8'h00;
			is_read <= 1'b0;
			op_hold <= 8'h00;
			busy <= 1'b0;
			nack <= 1'b0;
			refused <= 1'b0;
			result <= 16'h0000;
			lux <= 26'h0000000;
			mt_sh <= MT_RESET;
			half <= 1'b0;
			bus.scl_oe_h <= 1'b0;
			bus.sda_oe_h <= 1'b0;
		end else if (wr_go && avs_address_i == REG_CMD) begin
			if (busy || !bus.dvi_n || !legal) begin
				refused <= 1'b1;
			end else begin
				refused <= 1'b0;
				nack <= 1'b0;
				busy <= 1'b1;
				is_read <= avs_writedata_i[CMD_READ_BIT];
				op_hold <= wop;
				tx <= {bus.addr_sel ? ADDR_PIN_HI : ADDR_PIN_LO,
					avs_writedata_i[CMD_READ_BIT]};
				if (!avs_writedata_i[CMD_READ_BIT]) begin
					if (wop[7:3] == MT_HI_PFX || wop[7:5] == MT_LO_PFX) begin
						mt_sh <= mt_cand;
					end
					if (wop[7:4] == 4'h1 || wop[7:4] == 4'h2) begin
						half <= (wop[1:0] == RES_H2);
					end
				end
				byte_n <= 2'h0;
				q <= 2'h0;
				hst <= H_START;
			end
		end else if (qtick) begin
			q <= q + 2'h1;
			case (hst)
				H_START: begin
					if (q == 2'h1) bus.sda_oe_h <= 1'b1; // R22
					if (q == 2'h2) bus.scl_oe_h <= 1'b1;
					if (q == 2'h3) begin
						bit_n <= 4'h0;
						hst <= H_BIT;
					end
				end
				H_BIT: begin
					case (q)
						2'h0: begin
							if (bit_n != 4'h8) begin
								bus.sda_oe_h <= tx_byte & ~tx[7];
							end else begin
								bus.sda_oe_h <= ~tx_byte & (byte_n == 2'h1); // R21
							end
						end
						2'h1: bus.scl_oe_h <= 1'b0; // R3
						2'h2: begin
							if (bit_n != 4'h8) begin
								rx <= {rx[6:0], sda_s[1]};
								tx <= {tx[6:0], 1'b0};
							end else if (tx_byte && sda_s[1]) begin
								nack <= 1'b1;
							end
						end
						default: begin
							bus.scl_oe_h <= 1'b1;
							bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
							if (bit_n == 4'h8) begin
								if (nack) begin
									hst <= H_STOP;
								end else if (byte_n == 2'h0) begin
									byte_n <= 2'h1;
									tx <= op_hold; // R2
								end else if (is_read && byte_n == 2'h1) begin
									result[15:8] <= rx; // R21
									byte_n <= 2'h2;
								end else begin
									if (is_read) begin
										result[7:0] <= rx;
										lux <= (count * LUX_NUM) / lux_den; // R4
									end
									hst <= H_STOP;
								end
							end
						end
					endcase
				end
				H_STOP: begin
					if (q == 2'h0) bus.sda_oe_h <= 1'b1;
					if (q == 2'h1) bus.scl_oe_h <= 1'b0;
					if (q == 2'h2) bus.sda_oe_h <= 1'b0; // R2
					if (q == 2'h3) begin
						busy <= 1'b0;
						hst <= H_IDLE;
					end
				end
				default: hst <= H_IDLE;
			endcase
		end
	end

endmodule

// *** lsicp_props.sv ***
`timescale 1ns/1ps
module lsicp_props
	import lsicp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic scl_oe_h,
	input wire logic sda_oe_h,
	input wire logic sda_oe_d,
	input wire logic addr_sel,
	input wire logic dvi_n,
	input wire logic scl,
	input wire logic sda
);
	logic [9:0] lo_cnt;
	logic [9:0] hi_cnt;
	logic [7:0] hold_cnt;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// saturate so a long idle never wraps into a false short period
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			lo_cnt <= 10'h000;
		else if (scl)
			lo_cnt <= 10'h000;
		else if (lo_cnt != 10'h3FF)
			lo_cnt <= lo_cnt + 10'h001;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			hi_cnt <= 10'h000;
		else if (!scl)
			hi_cnt <= 10'h000;
		else if (hi_cnt != 10'h3FF)
			hi_cnt <= hi_cnt + 10'h001;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			hold_cnt <= 8'h00;
		else if (!dvi_n && hold_cnt != 8'hFF)
			hold_cnt <= hold_cnt + 8'h01;
	end

	a_dev_reset_quiet: assert property (!dvi_n |-> !sda_oe_d)
		else $error("device drives sda while held in reset");
	a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
		else $error("device moved sda while scl high");
	a_ack_delay: assert property ($rose(sda_oe_d) |-> !scl && lo_cnt <= 10'h008)
		else $error("device drive not shortly after scl fall");
	// low phase is two quarters, three after a start
	a_scl_low_time: assert property ($rose(scl) |->
		lo_cnt >= 10'(2 * SCL_QTR_CYC - 4)
		&& lo_cnt <= 10'(3 * SCL_QTR_CYC + 4))
		else $error("scl low period out of range");
	a_idle_quiet: assert property (hi_cnt > 10'h3E8 |-> !sda_oe_d)
		else $error("device holds sda on an idle bus");
	a_reset_out: assert property ($fell(rst_i) |-> !dvi_n && !scl_oe_h && !sda_oe_h)
		else $error("host lines active at reset release");
	a_dvi_hold: assert property ($rose(dvi_n) |-> hold_cnt >= 8'h64)
		else $error("sensor reset pin released too early");
	a_dvi_steady: assert property (dvi_n |=> dvi_n)
		else $error("sensor reset pin dropped in operation");
	a_addr_steady: assert property (!scl |-> $stable(addr_sel))
		else $error("address strap moved during a transfer");
endmodule

// *** light_sensor_i2c_command_port_bench.sv ***
`timescale 1ns/1ps
module light_sensor_i2c_command_port_bench
	import lsicp_pkg::*;
;
	logic        sys_clk_i    = 1'b0;
	logic        rst_i        = 1'b1;
	logic        av_rd        = 1'b0;
	logic        av_wr        = 1'b0;
	logic [4:0]  av_addr      = 5'h00;
	logic [31:0] av_wdata     = 32'h0;
	logic [31:0] av_rdata;
	logic [31:0] rdq;
	logic        av_wait;
	logic [15:0] light        = 16'h0123;
	logic        powered;
	logic        meas;
	int          meas_len     = 0;
	int          err_count    = 0;
	int          total_checks = 0;

	lsicp_if bus_if();
	lsicp_sensor_dev #(.T_UNIT_H(20), .T_UNIT_L(5)) lsicp_sensor_dev_i (
		.sys_clk_i    (sys_clk_i),
		.rst_i        (rst_i),
		.bus          (bus_if.dev),
		.light_i      (light),
		.powered_o    (powered),
		.meas_active_o(meas)
	);
	lsicp_host_ctrl lsicp_host_ctrl_i (
		.sys_clk_i        (sys_clk_i),
		.rst_i            (rst_i),
		.bus              (bus_if.host),
		.avs_address_i    (av_addr),
		.avs_read_i       (av_rd),
		.avs_write_i      (av_wr),
		.avs_writedata_i  (av_wdata),
		.avs_readdata_o   (av_rdata),
		.avs_waitrequest_o(av_wait)
	);
	lsicp_props lsicp_props_i (
		.sys_clk_i(sys_clk_i),
		.rst_i    (rst_i),
		.scl_oe_h (bus_if.scl_oe_h),
		.sda_oe_h (bus_if.sda_oe_h),
		.sda_oe_d (bus_if.sda_oe_d),
		.addr_sel (bus_if.addr_sel),
		.dvi_n    (bus_if.dvi_n),
		.scl      (bus_if.scl),
		.sda      (bus_if.sda)
	);

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// length of the current measurement, cleared by the test before it
	always @(posedge sys_clk_i) begin
		if (meas === 1'b1)
			meas_len <= meas_len + 1;
	end

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one bus cycle; read data taken at the edge that ends the wait
	task automatic av(input logic wr, input logic [4:0] a,
			input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= wr;
		av_rd <= ~wr;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (av_wait !== 1'b0 && n < 50);
		rdq = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			close_out();
		end
	endtask

	// command, then poll until the link transfer has finished
	task automatic cmd(input logic [8:0] op);
		int n;
		av(1'b1, REG_CMD, {23'h0, op});
		for (n = 0; n < 40000; n++) begin
			av(1'b0, REG_STATUS, 32'h0);
			if (rdq[STAT_BUSY] === 1'b0)
				break;
		end
		if (n >= 40000) begin
			chk(32'h0, 32'h1);
			close_out();
		end
	endtask

	task automatic t_boot();
		av(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rdq[STAT_LINK_UP]}, 32'h0);
		cmd(9'h001);
		av(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rdq[STAT_REFUSED]}, 32'h1);
		av(1'b0, 5'h14, 32'h0);
		chk(rdq, 32'h0);
		repeat (110) @(posedge sys_clk_i);
		av(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rdq[STAT_LINK_UP]}, 32'h1);
		chk({30'h0, bus_if.scl, bus_if.sda}, 32'h3);
		chk({31'h0, powered}, 32'h0);
		$display("t_boot done");
	endtask

	// doubled setting, single half-lux shot, clear ignored once down
	task automatic t_half();
		cmd(9'h044);
		cmd(9'h06A);
		cmd(9'h001);
		chk({31'h0, powered}, 32'h1);
		meas_len = 0;
		cmd(9'h021);
		repeat (3000) @(posedge sys_clk_i);
		chk(32'(meas_len > 2740 && meas_len < 2780), 32'h1);
		chk({31'h0, powered}, 32'h0);
		cmd(9'h007);
		cmd(9'h100);
		av(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rdq[STAT_NACK]}, 32'h0);
		av(1'b0, REG_RESULT, 32'h0);
		chk(rdq, 32'h048C);
		av(1'b0, REG_LUX, 32'h0);
		chk(rdq, 32'h00F2);
		$display("t_half done");
	endtask

	// other strap address, clear in power-on, then 4-lux continuous
	task automatic t_clr_low();
		av(1'b1, REG_CFG, 32'h1);
		cmd(9'h001);
		cmd(9'h007);
		cmd(9'h100);
		av(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rdq[STAT_NACK]}, 32'h0);
		av(1'b0, REG_RESULT, 32'h0);
		chk(rdq, 32'h0);
		cmd(9'h013);
		cmd(9'h100);
		chk({30'h0, powered, meas}, 32'h3);
		av(1'b0, REG_RESULT, 32'h0);
		chk(rdq, 32'h0091);
		cmd(9'h000);
		repeat (3) @(posedge sys_clk_i);
		chk({30'h0, powered, meas}, 32'h0);
		$display("t_clr_low done");
	endtask

	// one-shot 4-lux from power-down: 138 units of 5 cycles, then down
	task automatic t_one_low();
		meas_len = 0;
		cmd(9'h023);
		repeat (800) @(posedge sys_clk_i);
		chk(32'(meas_len > 680 && meas_len < 700), 32'h1);
		chk({30'h0, powered, meas}, 32'h0);
		$display("t_one_low done");
	endtask

	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_boot();
		t_half();
		t_clr_low();
		t_one_low();
		close_out();
	end
endmodule
